// File: crsmm_pkg.sv
// Constants for the core reset-state and memory-map block.
// Assumes a 32-bit APB register bus with word-aligned byte offsets.
package crsmm_pkg;

    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFF_STATUS = 8'h00;
    localparam logic [7:0] OFF_CMD    = 8'h04;
    localparam logic [7:0] OFF_PC     = 8'h08;
    localparam logic [7:0] OFF_XOP    = 8'h0C;
    localparam logic [7:0] OFF_WPTR   = 8'h10;
    localparam logic [7:0] OFF_NPTR   = 8'h14;
    localparam logic [7:0] OFF_FLAGS  = 8'h18;
    localparam logic [7:0] OFF_DADDR  = 8'h1C;
    localparam logic [7:0] OFF_DATA   = 8'h20;
    localparam logic [7:0] OFF_STACK  = 8'h24;
    localparam logic [7:0] OFF_R0     = 8'h28;
    localparam logic [7:0] OFF_P1     = 8'h2C;
    localparam logic [7:0] OFF_P4     = 8'h30;
    localparam logic [7:0] OFF_PINSEL = 8'h34;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int FLG_Z = 0;
    localparam int FLG_C = 1;
    localparam int FLG_E = 2;
    localparam int FLG_I = 3;
    localparam int CMD_CALL = 0;
    localparam int SEL_TIMER = 0;
    localparam int SEL_DIVCLK = 1;
    localparam int SEL_SERIAL = 2;
    localparam int SEL_SLAVE = 3;
    localparam int SEL_ADC = 4;

    // ------------------------------------------------------------
    // Reset values and memory map
    // ------------------------------------------------------------
    localparam logic [15:0] PC_RESET     = 16'h0110;
    localparam logic [15:0] VEC_NMI      = 16'h0100;
    localparam logic [15:0] ROM_LAST     = 16'h1FFF;
    localparam logic [15:0] RAM_LAST     = 16'h01FF;
    localparam logic [15:0] WIDE_FIRST   = 16'h0100;
    localparam logic [15:0] VEC_LAST     = 16'h010E;
    localparam logic [3:0]  PORT_HIGH    = 4'hF;
    localparam int          RAM_WORDS    = 512;
    localparam int          PUSH_NIBBLES = 4;

endpackage

// File: crsmm_core.sv
// Core reset state, code/data address decode, stack pointers with
// paired-write interrupt gating, and shared-terminal function select.
// Assumes APB master on pclk; interrupt requests and pins synchronous.
`timescale 1ns/1ps

module crsmm_core #(
    parameter bit PULL_UP = 1'b1
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        irq_req,
    input  wire logic [2:0]  irq_num,
    input  wire logic        nmi_req,
    input  wire logic        instr_done,
    output logic             irq_take,
    output logic             nmi_take,
    output logic             int_open,
    output logic             extended_mode,
    output logic      [15:0] pc_out,
    input  wire logic        timer_in,
    input  wire logic        divclk_in,
    input  wire logic        ser_out_bit,
    input  wire logic        ser_clk_out,
    input  wire logic        ser_ready,
    output logic      [3:0]  r0_out,
    input  wire logic [3:0]  p1_in,
    output logic      [3:0]  p1_out,
    output logic      [3:0]  p1_oe,
    output logic      [3:0]  p1_pull,
    input  wire logic [3:0]  p4_in,
    output logic      [3:0]  p4_out,
    output logic      [3:0]  p4_oe,
    output logic      [3:0]  p4_pull,
    output logic             serial_input_pin,
    output logic             sclk_from_pin,
    output logic             adc_select
);

    // ------------------------------------------------------------
    // Decode functions
    // ------------------------------------------------------------
    // Data RAM window
    function automatic logic ram_hit(input logic [15:0] a);
        ram_hit = (a <= crsmm_pkg::RAM_LAST);
    endfunction

    // Region that also allows 16-bit transfers
    function automatic logic wide_ok(input logic [15:0] a);
        wide_ok = (a >= crsmm_pkg::WIDE_FIRST) && ram_hit(a);
    endfunction

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [15:0] pc;
    logic [7:0]  extension_operand_register;
    logic [7:0]  wide_stack_pointer;
    logic [7:0]  nibble_stack_pointer;
    logic        i_flag;
    logic        e_flag;
    logic        c_flag;
    logic        z_flag;
    logic        wide_set;
    logic        nib_set;
    logic [15:0] daddr;
    logic [3:0]  r0_data;
    logic [3:0]  p1_data;
    logic [3:0]  p1_dir;
    logic [3:0]  p4_data;
    logic [3:0]  p4_dir;
    logic [4:0]  pinsel;
    logic [3:0]  ram [crsmm_pkg::RAM_WORDS];

    // ------------------------------------------------------------
    // APB address decode
    // ------------------------------------------------------------
    wire logic apb_setup = psel & ~penable;
    wire logic apb_done  = psel & penable & pready;
    wire logic apb_wr    = apb_done & pwrite;
    wire logic hit_stat  = (paddr == crsmm_pkg::OFF_STATUS);
    wire logic hit_cmd   = (paddr == crsmm_pkg::OFF_CMD);
    wire logic hit_pc    = (paddr == crsmm_pkg::OFF_PC);
    wire logic hit_xop   = (paddr == crsmm_pkg::OFF_XOP);
    wire logic hit_wptr  = (paddr == crsmm_pkg::OFF_WPTR);
    wire logic hit_nptr  = (paddr == crsmm_pkg::OFF_NPTR);
    wire logic hit_flg   = (paddr == crsmm_pkg::OFF_FLAGS);
    wire logic hit_dadr  = (paddr == crsmm_pkg::OFF_DADDR);
    wire logic hit_data  = (paddr == crsmm_pkg::OFF_DATA);
    wire logic hit_stk   = (paddr == crsmm_pkg::OFF_STACK);
    wire logic hit_r0    = (paddr == crsmm_pkg::OFF_R0);
    wire logic hit_p1    = (paddr == crsmm_pkg::OFF_P1);
    wire logic hit_p4    = (paddr == crsmm_pkg::OFF_P4);
    wire logic hit_sel   = (paddr == crsmm_pkg::OFF_PINSEL);
    wire logic hit_any   = hit_stat | hit_cmd | hit_pc | hit_xop | hit_wptr
                         | hit_nptr | hit_flg | hit_dadr | hit_data | hit_stk
                         | hit_r0 | hit_p1 | hit_p4 | hit_sel;

    wire logic wr_xop  = apb_wr & hit_xop;
    wire logic wr_wptr = apb_wr & hit_wptr;
    wire logic wr_nptr = apb_wr & hit_nptr;
    wire logic wr_flg = apb_wr & hit_flg;

    // ------------------------------------------------------------
    // Interrupt acceptance and call
    // ------------------------------------------------------------
    // Entry waits out a committing bus write so PC/SP writes never collide
    wire logic take_nmi = nmi_req & int_open & ~apb_wr;
    wire logic take_irq = irq_req & (irq_num != 3'h0) & i_flag & int_open
                        & ~apb_wr & ~nmi_req;
    wire logic entry    = take_nmi | take_irq;
    wire logic call     = apb_wr & hit_cmd & pwdata[crsmm_pkg::CMD_CALL];
    wire logic push_w   = entry | call;

    // Vector 0100H for NMI, 0100H + 2n for hardware source n = 1..7
    wire logic [15:0] vector = take_nmi ? crsmm_pkg::VEC_NMI
                             : crsmm_pkg::VEC_NMI + {12'h000, irq_num, 1'b0};

    // ------------------------------------------------------------
    // Stack addressing
    // ------------------------------------------------------------
    // 8-bit pointers wrap by themselves; wide pointer counts 4-nibble words
    wire logic [7:0] dec_wptr = wide_stack_pointer - 8'h01;
    wire logic [7:0] dec_nptr = nibble_stack_pointer - 8'h01;
    wire logic [15:0] wide_base = {6'h00, dec_wptr, 2'b00};
    wire logic [15:0] nib_addr  = {8'h00, dec_nptr};
    wire logic [15:0] stk_top   = {6'h00, wide_stack_pointer, 2'b00};
    wire logic [3:0]  flags_now = {i_flag, e_flag, c_flag, z_flag};
    wire logic        wide_wr   = push_w & wide_ok(wide_base);

    // Top of wide stack as one 16-bit read, outside the wide region zero
    wire logic [15:0] stk_word = wide_ok(stk_top) ?
                                 {ram[{stk_top[8:2], 2'b11}], ram[{stk_top[8:2], 2'b10}],
                                  ram[{stk_top[8:2], 2'b01}], ram[{stk_top[8:2], 2'b00}]}
                                 : 16'h0000;
    wire logic [3:0] data_nib = ram_hit(daddr) ? ram[daddr[8:0]] : 4'h0;

    // ------------------------------------------------------------
    // Next values of core state
    // ------------------------------------------------------------
    wire logic [15:0] next_pc = entry ? vector
                              : call ? pwdata[31:16]
                              : (apb_wr & hit_pc) ? pwdata[15:0] : pc;
    wire logic [7:0] next_wptr = push_w ? dec_wptr
                               : wr_wptr ? pwdata[7:0] : wide_stack_pointer;
    wire logic [7:0] next_nptr = entry ? dec_nptr
                               : wr_nptr ? pwdata[7:0] : nibble_stack_pointer;

    // A set from the extension write wins over the instruction-done clear
    wire logic next_e = wr_xop ? 1'b1
                      : wr_flg ? pwdata[crsmm_pkg::FLG_E]
                      : (entry | instr_done) ? 1'b0 : e_flag;
    wire logic next_i = wr_flg ? pwdata[crsmm_pkg::FLG_I]
                      : entry ? 1'b0 : i_flag;

    // Rewrite of one pointer while both are set drops the partner's flag
    wire logic pair_ok = wide_set & nib_set;
    wire logic next_wide_set = wr_wptr | (wide_set & ~(wr_nptr & pair_ok));
    wire logic next_nib_set  = wr_nptr | (nib_set & ~(wr_wptr & pair_ok));

    // Code space is fully addressable; only the low 8K steps hold ROM
    wire logic pc_in_rom = (pc <= crsmm_pkg::ROM_LAST);
    wire logic pc_in_vec = (pc >= crsmm_pkg::VEC_NMI) && (pc <= crsmm_pkg::VEC_LAST);

    // ------------------------------------------------------------
    // Read data selection
    // ------------------------------------------------------------
    wire logic [31:0] rd_data =
          hit_stat ? {27'h0, pc_in_vec, pc_in_rom, int_open, nib_set, wide_set}
        : hit_pc   ? {16'h0000, pc}
        : hit_xop  ? {24'h000000, extension_operand_register}
        : hit_wptr ? {24'h000000, wide_stack_pointer}
        : hit_nptr ? {24'h000000, nibble_stack_pointer}
        : hit_flg  ? {28'h0000000, flags_now}
        : hit_dadr ? {16'h0000, daddr}
        : hit_data ? {28'h0000000, data_nib}
        : hit_stk  ? {16'h0000, stk_word}
        : hit_r0   ? {28'h0000000, r0_data}
        : hit_p1   ? {20'h00000, p1_in, p1_dir, p1_data}
        : hit_p4   ? {20'h00000, p4_in, p4_dir, p4_data}
        : hit_sel  ? {27'h0, pinsel}
        : 32'h00000000;

    // ------------------------------------------------------------
    // Terminal function selection
    // ------------------------------------------------------------
    wire logic ser_en = pinsel[crsmm_pkg::SEL_SERIAL];
    wire logic slave  = pinsel[crsmm_pkg::SEL_SLAVE];
    wire logic adc_en = pinsel[crsmm_pkg::SEL_ADC];

    // Alternate outputs replace port data only when software selects them
    wire logic [3:0] next_r0 = {
        pinsel[crsmm_pkg::SEL_DIVCLK] ? divclk_in : r0_data[3],
        pinsel[crsmm_pkg::SEL_TIMER]  ? timer_in  : r0_data[2],
        r0_data[1:0]};

    // Serial: bit0 input, bit1 output, clock out in master, ready in slave
    wire logic [3:0] next_p1_oe  = ser_en ? {slave, ~slave, 1'b1, 1'b0} : p1_dir;
    wire logic [3:0] next_p1_out = ser_en ? {ser_ready, ser_clk_out, ser_out_bit, 1'b0}
                                          : p1_data;
    wire logic [3:0] next_p4_oe  = adc_en ? 4'h0 : p4_dir;
    wire logic [3:0] pull_all    = {4{PULL_UP}};

    // ------------------------------------------------------------
    // APB slave handshake
    // ------------------------------------------------------------
    // One wait state: read data is captured in setup, ready in access
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            prdata  <= 32'h00000000;
            pslverr <= 1'b0;
        end else begin
            pready <= psel & penable & ~pready;
            if (apb_setup) begin
                prdata  <= rd_data;
                pslverr <= ~hit_any;
            end else if (apb_done) begin
                pslverr <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Core registers
    // ------------------------------------------------------------
    // Z and C get a value too, so control state is never unknown
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pc      <= crsmm_pkg::PC_RESET;
            i_flag  <= 1'b0;
            e_flag  <= 1'b0;
            c_flag  <= 1'b0;
            z_flag  <= 1'b0;
            extension_operand_register <= 8'h00;
            wide_stack_pointer         <= 8'h00;
            nibble_stack_pointer       <= 8'h00;
            daddr   <= 16'h0000;
        end else begin
            pc     <= next_pc;
            i_flag <= next_i;
            e_flag <= next_e;
            wide_stack_pointer   <= next_wptr;
            nibble_stack_pointer <= next_nptr;
            if (wr_flg) begin
                c_flag <= pwdata[crsmm_pkg::FLG_C];
                z_flag <= pwdata[crsmm_pkg::FLG_Z];
            end
            if (wr_xop) begin
                extension_operand_register <= pwdata[7:0];
            end
            if (apb_wr && hit_dadr) begin
                daddr <= pwdata[15:0];
            end
        end
    end

    // ------------------------------------------------------------
    // Pointer written flags and interrupt gate
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wide_set <= 1'b0;
            nib_set  <= 1'b0;
            int_open <= 1'b0;
        end else begin
            wide_set <= next_wide_set;
            nib_set  <= next_nib_set;
            int_open <= next_wide_set & next_nib_set;
        end
    end

    // ------------------------------------------------------------
    // Data RAM
    // ------------------------------------------------------------
    // No reset: contents are undefined after reset by design
    always_ff @(posedge pclk) begin
        if (wide_wr) begin
            for (int n = 0; n < crsmm_pkg::PUSH_NIBBLES; n++) begin
                ram[{wide_base[8:2], n[1:0]}] <= pc[4*n +: 4];
            end
        end
        if (entry) begin
            ram[nib_addr[8:0]] <= flags_now;
        end
        if (apb_wr && hit_data && ram_hit(daddr)) begin
            ram[daddr[8:0]] <= pwdata[3:0];
        end
    end

    // ------------------------------------------------------------
    // Port registers
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r0_data <= crsmm_pkg::PORT_HIGH;
            p1_data <= 4'h0;
            p1_dir  <= 4'h0;
            p4_data <= 4'h0;
            p4_dir  <= 4'h0;
            pinsel  <= 5'h00;
        end else if (apb_wr) begin
            if (hit_r0) begin
                r0_data <= pwdata[3:0];
            end
            if (hit_p1) begin
                p1_data <= pwdata[3:0];
                p1_dir  <= pwdata[7:4];
            end
            if (hit_p4) begin
                p4_data <= pwdata[3:0];
                p4_dir  <= pwdata[7:4];
            end
            if (hit_sel) begin
                pinsel <= pwdata[4:0];
            end
        end
    end

    // ------------------------------------------------------------
    // Registered outputs
    // ------------------------------------------------------------
    // Pins lag their controls by one cycle; all outputs come from flops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_take         <= 1'b0;
            nmi_take         <= 1'b0;
            extended_mode    <= 1'b0;
            pc_out           <= crsmm_pkg::PC_RESET;
            r0_out           <= crsmm_pkg::PORT_HIGH;
            p1_out           <= 4'h0;
            p1_oe            <= 4'h0;
            p1_pull          <= 4'h0;
            p4_out           <= 4'h0;
            p4_oe            <= 4'h0;
            p4_pull          <= 4'h0;
            serial_input_pin <= 1'b0;
            sclk_from_pin    <= 1'b0;
            adc_select       <= 1'b0;
        end else begin
            irq_take         <= take_irq;
            nmi_take         <= take_nmi;
            extended_mode    <= next_e;
            pc_out           <= next_pc;
            r0_out           <= next_r0;
            p1_out           <= next_p1_out;
            p1_oe            <= next_p1_oe;
            p1_pull          <= pull_all & ~next_p1_oe;
            p4_out           <= p4_data;
            p4_oe            <= next_p4_oe;
            p4_pull          <= pull_all & ~next_p4_oe;
            serial_input_pin <= ser_en & p1_in[0];
            sclk_from_pin    <= ser_en & slave & p1_in[2];
            adc_select       <= adc_en;
        end
    end

endmodule

// File: crsmm_core_properties.sv
// Checker of crsmm_core: reset state, interrupt gating, vectors, pins.
// Sees the core's ports only; bound to every instance of the core.
`timescale 1ns/1ps
module crsmm_core_properties (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic        pready,
    input wire logic        nmi_req,
    input wire logic [2:0]  irq_num,
    input wire logic        irq_take,
    input wire logic        nmi_take,
    input wire logic        int_open,
    input wire logic        extended_mode,
    input wire logic [15:0] pc_out,
    input wire logic [3:0]  r0_out,
    input wire logic [3:0]  p1_oe,
    input wire logic [3:0]  p4_oe,
    input wire logic        adc_select
);
    // ------------------------------------
    // Write commits seen on the bus
    // ------------------------------------
    logic wr_c;
    logic sp_w;
    assign wr_c = psel && penable && pready && pwrite;
    assign sp_w = wr_c && (paddr == crsmm_pkg::OFF_WPTR || paddr == crsmm_pkg::OFF_NPTR);

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    // Steps: write commit to the extension register, allowed NMI cycle
    sequence xop_wr_s;
        wr_c && paddr == crsmm_pkg::OFF_XOP;
    endsequence
    sequence nmi_ok_s;
        int_open && nmi_req && !wr_c;
    endsequence

    reset_pc_a: assert property ($rose(presetn) |-> pc_out == crsmm_pkg::PC_RESET)
        else $error("pc not at start address after reset");
    reset_pins_a: assert property ($rose(presetn) |->
        r0_out == crsmm_pkg::PORT_HIGH && p1_oe == 4'h0 && !extended_mode && !int_open)
        else $error("bad state after reset");
    closed_gate_a: assert property (!int_open |=> !nmi_take && !irq_take)
        else $error("interrupt taken while gated");
    nmi_entry_a: assert property (nmi_ok_s |=> nmi_take && pc_out == crsmm_pkg::VEC_NMI)
        else $error("nmi entry missing or wrong vector");
    irq_vector_a: assert property (irq_take |->
        pc_out == crsmm_pkg::VEC_NMI + {12'h000, $past(irq_num), 1'b0})
        else $error("wrong maskable vector");
    no_source_a: assert property (irq_num == 3'h0 |=> !irq_take)
        else $error("maskable entry without source");
    open_cause_a: assert property ($rose(int_open) |-> $past(sp_w) || $past(sp_w, 2))
        else $error("gate opened without pointer write");
    remask_gate_a: assert property (int_open && sp_w |-> ##[1:2] !int_open)
        else $error("pointer rewrite did not mask");
    extend_set_a: assert property (xop_wr_s |-> ##[1:2] extended_mode)
        else $error("extension flag not set");
    adc_input_a: assert property (adc_select |-> p4_oe == 4'h0)
        else $error("converter pins driven");
endmodule

bind crsmm_core crsmm_core_properties i_props (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pready, .nmi_req, .irq_num,
    .irq_take, .nmi_take, .int_open, .extended_mode, .pc_out, .r0_out, .p1_oe, .p4_oe,
    .adc_select
);

// File: tb_crsmm_core.sv
// Self-checking bench of crsmm_core over APB with request pulses.
// Assumes one pclk domain and the checker bound to the core.
`timescale 1ns/1ps
module tb_crsmm_core;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [2:0]  req = 3'h0;
    logic [2:0]  irq_num = 3'h0;
    logic [12:0] misc = 13'h0;
    logic [31:0] prdata, q;
    logic        pready, pslverr, irq_take, nmi_take, int_open, extended_mode;
    logic        ser_in, sclk_in, adc_select, q_err;
    logic [15:0] pc_out, v;
    logic [3:0]  r0_out, p1_out, p1_oe, p1_pull, p4_out, p4_oe, p4_pull;
    int          err_total = 0;
    int          n_checks = 0;
    int          cyc = 0;
    // ------------------------------------
    // Clock, hang limit and device
    // ------------------------------------
    always #20 pclk = ~pclk;
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 8000) begin
            err_total++;
            summarize();
        end
    end
    crsmm_core i_crsmm_core (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .irq_num, .irq_take, .nmi_take, .int_open, .extended_mode, .pc_out, .r0_out,
        .p1_out, .p1_oe, .p1_pull, .p4_out, .p4_oe, .p4_pull, .adc_select,
        .nmi_req(req[0]), .irq_req(req[1]), .instr_done(req[2]), .timer_in(misc[0]),
        .divclk_in(misc[1]), .ser_out_bit(misc[2]), .ser_clk_out(misc[3]),
        .ser_ready(misc[4]), .p1_in(misc[8:5]), .p4_in(misc[12:9]),
        .serial_input_pin(ser_in), .sclk_from_pin(sclk_in)
    );
    // ------------------------------------
    // Tasks and expectations
    // ------------------------------------
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Request held until pready is sampled high, then released
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        q_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic rd(input logic [7:0] a);
        apb(1'b0, a, 32'h0);
    endtask
    // Registered outputs lag their cause; wait before looking
    task automatic settle;
        repeat (3) @(posedge pclk);
    endtask
    // Only instruction-done and request pulses; no sleep request exists
    task automatic pulse(input logic [2:0] b);
        req <= b;
        @(posedge pclk);
        req <= 3'h0;
        settle();
    endtask
    function automatic logic [15:0] vec(input logic [2:0] n);
        return (n == 3'h0) ? 16'h0123 : 16'h0100 + {12'h000, n, 1'b0};
    endfunction
    function automatic logic [1:0] area(input logic [15:0] p);
        return {p >= 16'h0100 && p <= 16'h010E, p <= 16'h1FFF};
    endfunction
    task automatic summarize;
        if (err_total == 0 && n_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // ------------------------------------
    // Main sequence
    // ------------------------------------
    initial begin
        void'($urandom(32'h1C7893CA));
        misc <= 13'($urandom);
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        rd(crsmm_pkg::OFF_PC);
        chk("pc_reg", 32'h0110, q);
        chk("pins", 32'hF0F0F, {12'h0, r0_out, p1_oe, p1_pull, p4_oe, p4_pull});
        rd(crsmm_pkg::OFF_FLAGS);
        chk("flags_ie", 32'h0, q & 32'hC);
        pulse(3'b001);
        chk("pc_locked", 32'h0110, {16'h0, pc_out});
        apb(1'b1, crsmm_pkg::OFF_WPTR, 32'h41);
        pulse(3'b001);
        chk("pc_half", 32'h0110, {16'h0, pc_out});
        apb(1'b1, crsmm_pkg::OFF_FLAGS, 32'h3);
        apb(1'b1, crsmm_pkg::OFF_NPTR, 32'h10);
        rd(crsmm_pkg::OFF_STATUS);
        chk("status", 32'h7, q & 32'h7);
        pulse(3'b001);
        chk("pc_nmi", 32'h0100, {16'h0, pc_out});
        rd(crsmm_pkg::OFF_STACK);
        chk("pc_push", 32'h0110, q);
        rd(crsmm_pkg::OFF_NPTR);
        chk("nib_ptr", 32'h0F, q);
        apb(1'b1, crsmm_pkg::OFF_DADDR, 32'h0F);
        rd(crsmm_pkg::OFF_DATA);
        chk("flag_push", 32'h3, q);
        apb(1'b1, crsmm_pkg::OFF_WPTR, 32'h41);
        apb(1'b1, crsmm_pkg::OFF_PC, 32'h0123);
        pulse(3'b001);
        chk("pc_remask", 32'h0123, {16'h0, pc_out});
        apb(1'b1, crsmm_pkg::OFF_NPTR, 32'h10);
        for (int n = 0; n < 8; n++) begin
            apb(1'b1, crsmm_pkg::OFF_FLAGS, 32'h8);
            apb(1'b1, crsmm_pkg::OFF_PC, 32'h0123);
            irq_num <= n[2:0];
            pulse(3'b010);
            chk("vector", {16'h0, vec(n[2:0])}, {16'h0, pc_out});
        end
        // Nibble pointer at zero wraps on entry; wide rewrite reopens first
        apb(1'b1, crsmm_pkg::OFF_NPTR, 32'h00);
        apb(1'b1, crsmm_pkg::OFF_WPTR, 32'h41);
        pulse(3'b001);
        rd(crsmm_pkg::OFF_NPTR);
        chk("nib_wrap", 32'hFF, q);
        apb(1'b1, crsmm_pkg::OFF_WPTR, 32'h41);
        apb(1'b1, crsmm_pkg::OFF_PC, 32'h1ABC);
        apb(1'b1, crsmm_pkg::OFF_CMD, 32'h0200_0001);
        settle();
        chk("pc_call", 32'h0200, {16'h0, pc_out});
        rd(crsmm_pkg::OFF_STACK);
        chk("call_push", 32'h1ABC, q);
        apb(1'b1, crsmm_pkg::OFF_WPTR, 32'h00);
        apb(1'b1, crsmm_pkg::OFF_CMD, 32'h0200_0001);
        rd(crsmm_pkg::OFF_WPTR);
        chk("wide_wrap", 32'hFF, q);
        rd(crsmm_pkg::OFF_STACK);
        chk("stack_narrow", 32'h0, q);
        // Written on purpose, followed by one instruction that may run extended
        apb(1'b1, crsmm_pkg::OFF_XOP, 32'h1A5);
        settle();
        chk("xmode_set", 32'h1, {31'h0, extended_mode});
        rd(crsmm_pkg::OFF_XOP);
        chk("xop_width", 32'hA5, q);
        pulse(3'b100);
        chk("xmode_done", 32'h0, {31'h0, extended_mode});
        // Random code and data addresses, boundaries first
        for (int i = 0; i < 24; i++) begin
            v = (i < 2) ? 16'h1FFF + 16'(i) : (i < 4) ? 16'h010D + 16'(i) : 16'($urandom);
            apb(1'b1, crsmm_pkg::OFF_PC, {16'h0, v});
            rd(crsmm_pkg::OFF_STATUS);
            chk("pc_area", {30'h0, area(v)}, {30'h0, q[4:3]});
            v = (i < 2) ? 16'h01FF + 16'(i) : 16'($urandom_range(0, 1023));
            apb(1'b1, crsmm_pkg::OFF_DADDR, {16'h0, v});
            apb(1'b1, crsmm_pkg::OFF_DATA, {28'h0, v[3:0] ^ 4'h9});
            rd(crsmm_pkg::OFF_DATA);
            chk("ram", (v <= 16'h01FF) ? {28'h0, v[3:0] ^ 4'h9} : 32'h0, q);
        end
        apb(1'b1, crsmm_pkg::OFF_PINSEL, 32'h1F);
        settle();
        chk("r0_alt", {30'h0, misc[1:0]}, {30'h0, r0_out[3:2]});
        chk("p1_slave", {22'h0, 4'hA, misc[4:2], 1'b0, misc[7], misc[5]},
            {22'h0, p1_oe, p1_out, sclk_in, ser_in});
        chk("adc", 32'h10, {27'h0, adc_select, p4_oe});
        apb(1'b1, crsmm_pkg::OFF_PINSEL, 32'h04);
        settle();
        chk("p1_master", 32'h6F, {24'h0, p1_oe, r0_out});
        // Plain port use: two bits driven, pull only on the inputs
        apb(1'b1, crsmm_pkg::OFF_P4, 32'h35);
        settle();
        chk("p4_port", 32'h35C, {20'h0, p4_oe, p4_out, p4_pull});
        rd(8'h38);
        chk("unmapped", 32'h1, {31'h0, q_err});
        summarize();
    end
endmodule
